// ---- squelch_detect_regs.sv ----
// Summary of operation
// - Status pin one in clock mode with squelch set is muted while the source is invalid.
// - Status pin zero in clock mode with squelch set is muted while invalid; squelch resets 0.
// - A cleared squelch bit keeps the status clock running regardless of source validity.
// - A status pin not in clock mode runs normally and ignores its squelch bit.
// - Six margin delay enables in bits 0 to 5, reset 0, one per channel group.
// - Bits 7:6 select secondary detection: 0 rising, 1 both, 2 falling; reset 1.
//
// Purpose: Configuration slice for status squelch, margin delay and detect method
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes: Source validity and clock mode inputs are asynchronous and synchronised
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "squelch_detect_map.svh"
module squelch_detect_regs
   import squelch_detect_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic source_valid_i,
   input wire logic status_pin_zero_clk_mode_i,
   input wire logic status_pin_one_clk_mode_i,
   input wire logic status_pin_zero_clk_i,
   input wire logic status_pin_one_clk_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic status_pin_zero_o,
   output logic status_pin_one_o,
   output logic [5:0] margin_delay_en_o,
   output logic [3:0] sec_detect_select_o
);
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must be 8 to 32");
   end

   // ==========================================================
   // State
   typedef struct packed {
      cfg_t cfg;
      wb_resp_t resp;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic pin0;
      logic pin1;
      logic [5:0] margin;
      logic [3:0] sel;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [3:0] sel_w;

   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      return 8'(a >> 2);
   endfunction

   function automatic logic pin_gate(input logic clk_mode, input logic squelch,
                                     input logic valid, input logic clk);
      return (clk_mode && squelch && !valid) ? 1'b0 : clk;
   endfunction

   method_decode u_dec (
      .method_i(s_q.cfg.sec_method),
      .select_o(sel_w)
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.sync1 = {source_valid_i, status_pin_one_clk_mode_i, status_pin_zero_clk_mode_i};
      s_d.sync2 = s_q.sync1;
      s_d.resp.ack = 1'b0;
      s_d.resp.dat = `DATA_ZERO;
      if (cyc_i && stb_i && !s_q.resp.ack) begin
         s_d.resp.ack = 1'b1;
         unique case (word_index(adr_i))
            `IDX_STATUS_PIN_SQUELCH_CTRL: begin
               s_d.resp.dat = {30'h0, s_q.cfg.squelch};
               if (we_i && sel_i[0]) begin
                  s_d.cfg.squelch = dat_i[`SQ_WIDTH-1:0];
               end
            end
            `IDX_DIVIDER_DYNAMIC_DELAY_CTRL: begin
               s_d.resp.dat = {26'h0, s_q.cfg.margin_en};
               if (we_i && sel_i[0]) begin
                  s_d.cfg.margin_en = dat_i[`DLY_WIDTH-1:0];
               end
            end
            `IDX_REFERENCE_DETECT_CTRL: begin
               s_d.resp.dat = {24'h00_0000, s_q.cfg.sec_method, s_q.cfg.refdet_low};
               if (we_i && sel_i[0]) begin
                  s_d.cfg.sec_method = dat_i[`DET_MSB:`DET_LSB];
                  s_d.cfg.refdet_low = dat_i[`DET_LSB-1:0];
               end
            end
            default: s_d.resp.dat = `DATA_ZERO;
         endcase
      end
      s_d.pin0 = pin_gate(s_q.sync2[0], s_q.cfg.squelch[`SQ_ZERO_BIT], s_q.sync2[2],
                          status_pin_zero_clk_i);
      s_d.pin1 = pin_gate(s_q.sync2[1], s_q.cfg.squelch[`SQ_ONE_BIT], s_q.sync2[2],
                          status_pin_one_clk_i);
      s_d.margin = s_q.cfg.margin_en;
      s_d.sel = sel_w;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.cfg.squelch <= `SQ_RESET;
         s_q.cfg.margin_en <= `DLY_RESET;
         s_q.cfg.sec_method <= `DET_RESET;
         s_q.cfg.refdet_low <= `REFDET_LOW_RESET;
         s_q.sel <= `SEL_BOTH;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o = s_q.resp.dat;
   assign ack_o = s_q.resp.ack;
   assign status_pin_zero_o = s_q.pin0;
   assign status_pin_one_o = s_q.pin1;
   assign margin_delay_en_o = s_q.margin;
   assign sec_detect_select_o = s_q.sel;

   // ==========================================================
   // Checks
   a_pin_one_mute: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.sync2[1] && s_q.cfg.squelch[`SQ_ONE_BIT] && !s_q.sync2[2])
      |=> !status_pin_one_o
   )
   else $error("status pin one not muted");

   a_pin_zero_mute: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.sync2[0] && s_q.cfg.squelch[`SQ_ZERO_BIT] && !s_q.sync2[2])
      |=> !status_pin_zero_o
   )
   else $error("status pin zero not muted");

   a_valid_pass_one: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_q.sync2[2]
      |=> status_pin_one_o == $past(status_pin_one_clk_i)
   )
   else $error("pin one blocked with valid source");

   a_squelch_off_pass: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s_q.cfg.squelch[`SQ_ZERO_BIT]
      |=> status_pin_zero_o == $past(status_pin_zero_clk_i)
   )
   else $error("pin zero blocked with squelch off");

   a_squelch_off_one: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s_q.cfg.squelch[`SQ_ONE_BIT]
      |=> status_pin_one_o == $past(status_pin_one_clk_i)
   )
   else $error("pin one blocked with squelch off");

   a_no_clk_mode: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s_q.sync2[1]
      |=> status_pin_one_o == $past(status_pin_one_clk_i)
   )
   else $error("pin one blocked outside clock mode");

   a_no_clk_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !s_q.sync2[0]
      |=> status_pin_zero_o == $past(status_pin_zero_clk_i)
   )
   else $error("pin zero blocked outside clock mode");

   // ==========================================================
   // Register checks
   a_squelch_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(we_i && sel_i[0]) && $past(word_index(adr_i)) == `IDX_STATUS_PIN_SQUELCH_CTRL)
      |-> s_q.cfg.squelch == $past(dat_i[`SQ_WIDTH-1:0])
   )
   else $error("squelch bits not written");

   a_squelch_readback: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(!we_i) && $past(word_index(adr_i)) == `IDX_STATUS_PIN_SQUELCH_CTRL)
      |-> dat_o == {30'h0, $past(s_q.cfg.squelch)}
   )
   else $error("squelch read data wrong");

   a_margin_follow: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(we_i && sel_i[0]) && $past(word_index(adr_i)) == `IDX_DIVIDER_DYNAMIC_DELAY_CTRL)
      |=> margin_delay_en_o == $past(dat_i[`DLY_WIDTH-1:0], 2)
   )
   else $error("margin enables not updated");

   a_margin_refused: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && we_i && !sel_i[0])
      |=> $stable(s_q.cfg.margin_en)
   )
   else $error("margin changed by refused write");

   a_method_readback: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(!we_i) && $past(word_index(adr_i)) == `IDX_REFERENCE_DETECT_CTRL)
      |-> dat_o[`DET_MSB:`DET_LSB] == $past(s_q.cfg.sec_method)
   )
   else $error("method read data wrong");

   a_method_rise: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg.sec_method == `DET_RISE)
      |=> sec_detect_select_o == `SEL_RISE
   )
   else $error("rising method not selected");

   a_method_both: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg.sec_method == `DET_BOTH)
      |=> sec_detect_select_o == `SEL_BOTH
   )
   else $error("both edges method not selected");

   a_method_map: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg.sec_method == `DET_FALL)
      |=> sec_detect_select_o == `SEL_FALL
   )
   else $error("falling method not selected");

   a_level_map: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (s_q.cfg.sec_method == `DET_LEVEL)
      |=> sec_detect_select_o == `SEL_LEVEL
   )
   else $error("level detector not selected");

   // ==========================================================
   // Bus checks
   a_ack_one: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_o
      |=> !ack_o
   )
   else $error("ack held too long");

   a_ack_answer: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o)
      |=> ack_o
   )
   else $error("request not answered");

   a_dat_idle_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !ack_o
      |-> dat_o == `DATA_ZERO
   )
   else $error("read data not zero when idle");

   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(word_index(adr_i)) != `IDX_STATUS_PIN_SQUELCH_CTRL
         && $past(word_index(adr_i)) != `IDX_DIVIDER_DYNAMIC_DELAY_CTRL
         && $past(word_index(adr_i)) != `IDX_REFERENCE_DETECT_CTRL)
      |-> dat_o == `DATA_ZERO
   )
   else $error("unmapped read not zero");

   // ==========================================================
   // Coverage
   c_write: cover property (
      @(posedge clk_i) ack_o && $past(we_i)
   );

   c_mute: cover property (
      @(posedge clk_i) s_q.sync2[1] && !s_q.sync2[2]
   );

   c_level: cover property (
      @(posedge clk_i) s_q.cfg.sec_method == `DET_LEVEL
   );

   c_refused_write: cover property (
      @(posedge clk_i) cyc_i && stb_i && we_i && !sel_i[0] && !ack_o
   );

   c_pin_zero_mute: cover property (
      @(posedge clk_i) s_q.sync2[0] && s_q.cfg.squelch[`SQ_ZERO_BIT] && !s_q.sync2[2]
   );
endmodule

// ---- squelch_detect_map.svh ----
// Purpose: Register offsets, field positions, reset values and codes
// Assumes: Register index times four gives the byte address
// Notes: Definitions only
`ifndef SQUELCH_DETECT_MAP_SVH
`define SQUELCH_DETECT_MAP_SVH

// ==========================================================
// Register indexes
`define IDX_STATUS_PIN_SQUELCH_CTRL 8'h17
`define IDX_DIVIDER_DYNAMIC_DELAY_CTRL 8'h18
`define IDX_REFERENCE_DETECT_CTRL 8'h19

// ==========================================================
// Field positions and widths
`define SQ_ZERO_BIT 0
`define SQ_ONE_BIT 1
`define SQ_WIDTH 2
`define DLY_WIDTH 6
`define DET_LSB 6
`define DET_MSB 7

// ==========================================================
// Reset values
`define SQ_RESET 2'h2
`define DLY_RESET 6'h00
`define DET_RESET 2'h1
`define REFDET_LOW_RESET 6'h00

// ==========================================================
// Detection method codes
`define DET_RISE 2'h0
`define DET_BOTH 2'h1
`define DET_FALL 2'h2
`define DET_LEVEL 2'h3

// ==========================================================
// Selector codes
`define SEL_RISE 4'h1
`define SEL_BOTH 4'h2
`define SEL_FALL 4'h4
`define SEL_LEVEL 4'h8
`define DATA_ZERO 32'h0000_0000
`endif

// ---- squelch_detect_pkg.sv ----
// Purpose: Types shared by the register slice
// Assumes: Map header supplies numbers
// Notes: None
package squelch_detect_pkg;
   typedef struct packed {
      logic [31:0] dat;
      logic ack;
   } wb_resp_t;

   typedef struct packed {
      logic [1:0] squelch;
      logic [5:0] margin_en;
      logic [1:0] sec_method;
      logic [5:0] refdet_low;
   } cfg_t;
endpackage

// ---- method_decode.sv ----
// Purpose: Decode the secondary detection method into one-hot selects
// Assumes: Two-bit method code
// Notes: Combinational
`timescale 1ns/1ps
`include "squelch_detect_map.svh"
module method_decode (
   input wire logic [1:0] method_i,
   output logic [3:0] select_o
);
   // ==========================================================
   // Decode
   always_comb begin
      unique case (method_i)
         `DET_RISE: select_o = `SEL_RISE;
         `DET_BOTH: select_o = `SEL_BOTH;
         `DET_FALL: select_o = `SEL_FALL;
         `DET_LEVEL: select_o = `SEL_LEVEL;
      endcase
   end
endmodule

// ---- squelch_detect_regs_bench.sv ----
// Purpose: Self-checking bench for the squelch, margin and detect-method register slice
// Assumes: One request per ack, ack one cycle after the request is taken
// Notes: Read results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module squelch_detect_regs_bench;
   import squelch_detect_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o;
   logic source_valid_i = 1, status_pin_zero_clk_mode_i = 0, status_pin_one_clk_mode_i = 0;
   logic status_pin_zero_clk_i = 0, status_pin_one_clk_i = 0;
   logic ack_o, status_pin_zero_o, status_pin_one_o;
   logic [5:0] margin_delay_en_o;
   logic [3:0] sec_detect_select_o;
   logic [32:0] exp_q[$];
   logic [31:0] xs = 32'h0000_003E;
   logic [31:0] r;
   int num_errors = 0, comparisons = 0, cycles = 0;
   logic m, s, v, e0, e1;
   // ==========================================================
   // Design
   squelch_detect_regs #(.ADDR_W(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .source_valid_i(source_valid_i), .status_pin_zero_clk_mode_i(status_pin_zero_clk_mode_i),
      .status_pin_one_clk_mode_i(status_pin_one_clk_mode_i),
      .status_pin_zero_clk_i(status_pin_zero_clk_i), .status_pin_one_clk_i(status_pin_one_clk_i),
      .dat_o(dat_o), .ack_o(ack_o), .status_pin_zero_o(status_pin_zero_o),
      .status_pin_one_o(status_pin_one_o), .margin_delay_en_o(margin_delay_en_o),
      .sec_detect_select_o(sec_detect_select_o));
   // ==========================================================
   // Clock, timeout and helpers
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   // ==========================================================
   // Wishbone master and read monitor
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [32:0] note);
      exp_q.push_back(note);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= be;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000, 4'hF, {1'b1, e});
   endtask
   always @(posedge clk_i) begin
      if (ack_o === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected ack", 32'h0000_0000, 32'h0000_0001);
         else if (exp_q[0][32]) check("read data", exp_q[0][31:0], dat_o);
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h5C, 32'h0000_0002);
      rd(8'h60, 32'h0000_0000);
      rd(8'h64, 32'h0000_0040);
      check("select", 32'h2, {28'h0, sec_detect_select_o});
      wb(1'b1, 8'h00, 32'h0000_00FF, 4'hF, 33'h0);
      rd(8'h00, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         wb(1'b1, 8'h64, {24'h0, i[1:0], r[5:0]}, 4'hF, 33'h0);
         rd(8'h64, {24'h0, i[1:0], r[5:0]});
         check("select", 32'h1 << i, {28'h0, sec_detect_select_o});
      end
      r = rnd();
      wb(1'b1, 8'h60, r, 4'hF, 33'h0);
      wb(1'b1, 8'h60, ~r, 4'hE, 33'h0);
      rd(8'h60, {26'h0, r[5:0]});
      check("margin", {26'h0, r[5:0]}, {26'h0, margin_delay_en_o});
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         {m, s, v} = k[2:0];
         status_pin_zero_clk_mode_i <= m;
         status_pin_one_clk_mode_i <= m;
         source_valid_i <= v;
         status_pin_zero_clk_i <= r[0];
         status_pin_one_clk_i <= r[1];
         wb(1'b1, 8'h5C, {30'h0, s, s}, 4'hF, 33'h0);
         repeat (6) @(posedge clk_i);
         e0 = r[0] & ~(m & s & ~v);
         e1 = r[1] & ~(m & s & ~v);
         check("pin zero", {31'h0, e0}, {31'h0, status_pin_zero_o});
         check("pin one", {31'h0, e1}, {31'h0, status_pin_one_o});
      end
      finish_test();
   end
endmodule
